//--- pkg/flash_seq_regs.svh
/*
 * Opcodes, address field positions, page lengths and timing counts of the
 * buffered page program sequencer. Assumes a 40 ns system clock.
 */
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// command opcodes
`define OPC_PROG_ERASE_B1  8'h82
`define OPC_PROG_ERASE_B2  8'h85
`define OPC_BYTE_PROG      8'h02
`define OPC_RMW_B1         8'h58
`define OPC_RMW_B2         8'h59

// page lengths in bytes and page index position in the 24-bit address
`define PAGE_LEN_528       10'h210
`define PAGE_LEN_512       10'h200
`define PAGE_LSB_528       10
`define PAGE_LSB_512       9

// timing: longest times round down to whole cycles
`define CLK_PERIOD_NS      40
`define ERASE_TIME_NS      2000
`define BYTE_WRITE_TIME_NS 200
`define ERASE_CYC          (`ERASE_TIME_NS / `CLK_PERIOD_NS)
`define BYTE_WRITE_CYC     (`BYTE_WRITE_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- pkg/flash_seq_pkg.sv
/*
 * Types of the buffered page program sequencer: states, commands and the
 * state records of the link side and the sequencing side.
 */
package flash_seq_pkg;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_OPC       = 4'h1,
    ST_ADDR      = 4'h2,
    ST_DATA      = 4'h3,
    ST_SKIP      = 4'h4,
    ST_COPY_RD   = 4'h5,
    ST_COPY_WR   = 4'h6,
    ST_ERASE     = 4'h7,
    ST_PROG_RD   = 4'h8,
    ST_PROG_WR   = 4'h9,
    ST_PROG_WAIT = 4'hA
  } seq_state_t;

  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_PE   = 2'h1,
    CMD_BP   = 2'h2,
    CMD_RMW  = 2'h3
  } cmd_t;

  typedef struct packed {
    logic [6:0] acc;
    logic [7:0] data;
    logic       tgl;
    logic       partial;
  } link_t;

  typedef struct packed {
    seq_state_t state;
    cmd_t       cmd;
    logic       buf_sel;
    logic [1:0] hdr;
    logic [23:0] addr;
    logic [9:0] start;
    logic [9:0] wptr;
    logic [9:0] nload;
    logic [9:0] off;
    logic [9:0] idx;
    logic [7:0] tmr;
    logic       fail;
    logic       busy;
    logic       erase;
    logic       we;
    logic [7:0] wdata;
    logic [11:0] page;
    logic [3:0] cs_s;
    logic [2:0] tg_s;
    logic [1:0] pt_s;
    logic [1:0] md_s;
  } seq_t;

endpackage

//--- logic/buffer_ram.sv
/*
 * Two page buffers of 1024 byte slots each, one port, registered read.
 * Assumes one access per clock from the sequencer.
 */
`timescale 1ns/10ps
module buffer_ram (
  input  wire logic        sys_clk,
  input  wire logic        we,
  input  wire logic [10:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);

  logic [7:0] mem [0:2047];

  // read first, read data (the old byte) one cycle later
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

//--- logic/page_program_sequencer.sv
/*
 * Command sequencer for buffered page programming of a serial flash:
 * program through buffer with erase, byte/page program, read-modify-write.
 * Assumes the host owns spi_clk and cs_n, and that the array answers a
 * read one sys_clk after its address and raises array_fail on bad erase.
 */
// What this block does
// - opcode 82h buffer one, 85h buffer two
// - 528 mode: 2 dummy, page, 10-bit offset
// - 512 mode: 3 dummy, page, 9-bit offset
// - data fills buffer, offset wraps to zero
// - select rise: erase page, then program buffer
// - ready flag shows busy during timed work
// - failed byte sets program erase fail flag
// - opcode 02h always loads buffer one
// - 02h programs only the loaded bytes
// - 512 mode page and offset form linear address
// - partial last byte aborts 02h and modify
// - 02h time is loaded bytes times (write time + 2 cycles)
// - modify opcode 58h buffer one, 59h two
// - modify 528 mode: 2 dummy, page, 10-bit byte
// - modify 512 mode: 3 dummy, page, 9-bit byte
// - modify copies page, merges, erases, reprograms
// - modify with no data rewrites the page
// - modify self-timed with busy held throughout
`timescale 1ns/10ps
`include "flash_seq_regs.svh"
module page_program_sequencer (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        spi_clk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic        page_528,
  input  wire logic [7:0]  array_rdata,
  input  wire logic        array_fail,
  output logic             ready_flag,
  output logic             program_erase_fail_flag,
  output logic             array_erase,
  output logic             array_we,
  output logic      [7:0]  array_wdata,
  output logic      [11:0] array_page,
  output logic      [9:0]  array_col
);
  import flash_seq_pkg::*;

  link_t       lr;
  link_t       ln;
  logic [2:0]  bit_cnt;
  seq_t        sr;
  seq_t        sn;
  logic        m528;
  logic        byte_ev;
  logic        frame_start;
  logic        frame_end;
  logic [7:0]  rx_byte;
  logic [9:0]  len;
  logic [9:0]  total;
  logic        ram_we;
  logic [10:0] ram_addr;
  logic [7:0]  ram_wdata;
  logic [7:0]  ram_rdata;
  logic [9:0]  we_cnt;

  function automatic logic [9:0] page_len(input logic m);
    page_len = m ? `PAGE_LEN_528 : `PAGE_LEN_512;
  endfunction

  function automatic logic [9:0] wrap_inc(input logic [9:0] o, input logic m);
    wrap_inc = (o == page_len(m) - 10'h001) ? 10'h000 : o + 10'h001;
  endfunction

  // page index above the offset field
  // in 512 mode page and offset are address bits 20..0
  function automatic logic [11:0] page_of(input logic [23:0] a, input logic m);
    page_of = m ? a[`PAGE_LSB_528 +: 12] : a[`PAGE_LSB_512 +: 12];
  endfunction

  // same split gives the modify start byte
  function automatic logic [9:0] start_of(input logic [23:0] a, input logic m);
    start_of = m ? a[9:0] : {1'b0, a[8:0]};
  endfunction

  // byte was loaded when its distance from the start is below the count
  function automatic logic in_run(input logic [9:0] o, input logic [9:0] s,
                                  input logic [9:0] n, input logic m);
    logic [9:0] d;
    d = (o >= s) ? o - s : o + page_len(m) - s;
    in_run = d < n;
  endfunction

  function automatic logic frame_state(input seq_state_t s);
    frame_state = (s == ST_OPC) || (s == ST_ADDR) || (s == ST_DATA) || (s == ST_SKIP);
  endfunction

  // link side: bit counter cleared while the host deselects
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 3'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // byte assembly; completed byte held stable for the toggle handshake
  always_comb begin
    ln = lr;
    ln.acc = {lr.acc[5:0], mosi};
    ln.partial = (bit_cnt != 3'h7);
    if (bit_cnt == 3'h7) begin
      ln.data = {lr.acc, mosi};
      ln.tgl = ~lr.tgl;
    end
  end

  // spi_clk is still during reset, so the asynchronous clear is safe
  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      lr <= '0;
    end else begin
      lr <= ln;
    end
  end

  // frame end waits one more stage so the last byte is handled first
  assign m528        = sr.md_s[1];
  assign byte_ev     = sr.tg_s[1] ^ sr.tg_s[2];
  assign frame_start = !sr.cs_s[1] && sr.cs_s[2];
  assign frame_end   = sr.cs_s[2] && !sr.cs_s[3];
  assign rx_byte     = lr.data;
  assign len         = page_len(m528);
  assign total       = (sr.cmd == CMD_BP) ? sr.nload : len;

  // buffer writes during data phase, page copy keeps unloaded bytes
  // merge: copied page bytes skip the freshly loaded run
  assign ram_we    = (sr.state == ST_DATA && byte_ev) ||
                     (sr.state == ST_COPY_WR && !in_run(sr.off, sr.start, sr.nload, m528));
  assign ram_addr  = {sr.buf_sel, (sr.state == ST_DATA) ? sr.wptr : sr.off};
  assign ram_wdata = (sr.state == ST_DATA) ? rx_byte : array_rdata;

  buffer_ram u_buf (
    .sys_clk (sys_clk),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (ram_wdata),
    .rdata   (ram_rdata)
  );

  // sequencing side next state
  always_comb begin
    sn = sr;
    sn.erase = 1'b0;
    sn.we = 1'b0;
    sn.cs_s = {sr.cs_s[2:0], cs_n};
    sn.tg_s = {sr.tg_s[1:0], lr.tgl};
    sn.pt_s = {sr.pt_s[0], lr.partial};
    sn.md_s = {sr.md_s[0], page_528};
    case (sr.state)
      ST_IDLE: begin
        if (frame_start) sn.state = ST_OPC;
      end
      ST_OPC: begin
        if (byte_ev) begin
          sn.hdr = 2'h0;
          sn.state = ST_ADDR;
          case (rx_byte)
            `OPC_PROG_ERASE_B1: begin sn.cmd = CMD_PE; sn.buf_sel = 1'b0; end
            `OPC_PROG_ERASE_B2: begin sn.cmd = CMD_PE; sn.buf_sel = 1'b1; end
            // byte program always uses buffer one
            `OPC_BYTE_PROG: begin sn.cmd = CMD_BP; sn.buf_sel = 1'b0; end
            `OPC_RMW_B1: begin sn.cmd = CMD_RMW; sn.buf_sel = 1'b0; end
            `OPC_RMW_B2: begin sn.cmd = CMD_RMW; sn.buf_sel = 1'b1; end
            default: begin sn.cmd = CMD_NONE; sn.state = ST_SKIP; end
          endcase
        end
      end
      ST_ADDR: begin
        if (byte_ev) begin
          sn.addr = {sr.addr[15:0], rx_byte};
          sn.hdr = sr.hdr + 2'h1;
          if (sr.hdr == 2'h2) begin
            sn.state = ST_DATA;
            sn.start = start_of(sn.addr, m528);
            sn.wptr = sn.start;
            sn.nload = 10'h000;
          end
        end
      end
      ST_DATA: begin
        if (byte_ev) begin
          // successive offsets, wrap past the last one
          sn.wptr = wrap_inc(sr.wptr, m528);
          if (sr.nload != len) sn.nload = sr.nload + 10'h001;
        end
      end
      ST_SKIP: begin
      end
      ST_COPY_RD: begin
        sn.state = ST_COPY_WR;
      end
      ST_COPY_WR: begin
        if (sr.idx == len - 10'h001) begin
          sn.state = ST_ERASE;
          sn.erase = 1'b1;
          sn.tmr = 8'(`ERASE_CYC - 1);
        end else begin
          sn.idx = sr.idx + 10'h001;
          sn.off = wrap_inc(sr.off, m528);
          sn.state = ST_COPY_RD;
        end
      end
      ST_ERASE: begin
        // erase failure reported by the array
        if (array_fail) sn.fail = 1'b1;
        if (sr.tmr == 8'h00) begin
          sn.state = ST_PROG_RD;
          sn.off = 10'h000;
          sn.idx = 10'h000;
        end else begin
          sn.tmr = sr.tmr - 8'h01;
        end
      end
      ST_PROG_RD: begin
        sn.state = ST_PROG_WR;
      end
      ST_PROG_WR: begin
        // each byte waits one byte write time, counted from the cycle of its write pulse
        sn.we = 1'b1;
        sn.wdata = ram_rdata;
        sn.tmr = 8'(`BYTE_WRITE_CYC - 1);
        sn.state = ST_PROG_WAIT;
      end
      ST_PROG_WAIT: begin
        if (sr.tmr != 8'h00) begin
          sn.tmr = sr.tmr - 8'h01;
        end else begin
          // read back and compare each programmed byte
          if (array_rdata != sr.wdata) sn.fail = 1'b1;
          if (sr.idx == total - 10'h001) begin
            sn.state = ST_IDLE;
          end else begin
            sn.idx = sr.idx + 10'h001;
            sn.off = wrap_inc(sr.off, m528);
            sn.state = ST_PROG_RD;
          end
        end
      end
      default: begin
        sn.state = ST_IDLE;
      end
    endcase
    // select rise ends the frame and may launch the timed operation
    if (frame_end && frame_state(sr.state)) begin
      sn.state = ST_IDLE;
      // a partial byte aborts byte program and modify
      if (sr.state == ST_DATA && !(sr.pt_s[1] && sr.cmd != CMD_PE)) begin
        sn.page = page_of(sr.addr, m528);
        sn.fail = 1'b0;
        sn.idx = 10'h000;
        case (sr.cmd)
          CMD_PE: begin
            // erase first, programming follows the erase wait
            sn.erase = 1'b1;
            sn.tmr = 8'(`ERASE_CYC - 1);
            sn.state = ST_ERASE;
          end
          CMD_BP: begin
            // only the loaded run is programmed, starting at its offset
            if (sr.nload != 10'h000) begin
              sn.off = sr.start;
              sn.state = ST_PROG_RD;
            end
          end
          CMD_RMW: begin
            // page copy first; zero loaded bytes rewrites all
            sn.off = 10'h000;
            sn.state = ST_COPY_RD;
          end
          default: begin
          end
        endcase
      end
    end
    sn.busy = !frame_state(sn.state) && (sn.state != ST_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sr      <= '0;
      sr.cs_s <= 4'hF; // select idles high: no false frame end after reset
    end else begin
      sr <= sn;
    end
  end

  assign ready_flag              = !sr.busy;
  assign program_erase_fail_flag = sr.fail;
  assign array_erase             = sr.erase;
  assign array_we                = sr.we;
  assign array_wdata             = sr.wdata;
  assign array_page              = sr.page;
  assign array_col               = sr.off;

  // writes since the frame ended, for checking the byte program count
  always_ff @(posedge sys_clk) begin
    if (!rst_n || frame_end) begin
      we_cnt <= 10'h000;
    end else if (sr.we) begin
      we_cnt <= we_cnt + 10'h001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence erase_start_s;
    array_erase && !ready_flag;
  endsequence
  sequence erase_hold_s;
    !array_we [*8];
  endsequence

  opcode_decode_a: assert property (
    sr.state == ST_OPC && byte_ev && rx_byte == `OPC_PROG_ERASE_B2
    |=> sr.cmd == CMD_PE && sr.buf_sel)
    else $error("85h not decoded as buffer two erase program");
  bp_buffer_a: assert property (
    sr.state == ST_OPC && byte_ev && rx_byte == `OPC_BYTE_PROG
    |=> sr.cmd == CMD_BP && !sr.buf_sel)
    else $error("02h not decoded to buffer one");
  offset_wrap_a: assert property (
    sr.state == ST_DATA && byte_ev && !frame_end && sr.wptr == len - 10'h001
    |=> sr.wptr == 10'h000)
    else $error("buffer offset did not wrap");
  erase_first_a: assert property (
    erase_start_s |-> ##1 erase_hold_s)
    else $error("program write during erase wait");
  busy_hold_a: assert property (
    array_we |-> !ready_flag [*3])
    else $error("ready shown while programming");
  fail_set_a: assert property (
    sr.state == ST_PROG_WAIT && sr.tmr == 8'h00 && array_rdata != sr.wdata
    |=> program_erase_fail_flag)
    else $error("failed byte not flagged");
  partial_abort_a: assert property (
    frame_end && sr.state == ST_DATA && sr.pt_s[1] && sr.cmd == CMD_BP
    |=> ready_flag && sr.state == ST_IDLE [*2])
    else $error("partial byte did not abort");
  bp_count_a: assert property (
    sr.cmd == CMD_BP && sr.state == ST_PROG_WAIT && sr.tmr == 8'h00 &&
    sr.idx == total - 10'h001 |-> we_cnt == sr.nload)
    else $error("byte program count differs from loaded count");
  copy_then_erase_a: assert property (
    sr.state == ST_COPY_WR && sr.idx == len - 10'h001 |=> array_erase ##1 !ready_flag)
    else $error("modify did not erase after page copy");
  rewrite_copy_a: assert property (
    sr.cmd == CMD_RMW && sr.nload == 10'h000 && sr.state == ST_COPY_WR |-> ram_we)
    else $error("page rewrite skipped a copied byte");
  linear_addr_a: assert property (
    frame_end && sr.state == ST_DATA && !sr.pt_s[1] && !m528 && sr.cmd == CMD_PE
    |=> {array_page, sr.start[8:0]} == $past(sr.addr[20:0]))
    else $error("512 mode address not linear");

endmodule

//--- tb/host_link_model.sv
/*
 * Behavioural serial host that frames commands for the sequencer.
 * Assumes the bench calls send() only once the device reports ready.
 */
`timescale 1ns/10ps
module host_link_model (
  output logic spi_clk,
  output logic cs_n,
  output logic mosi
);
  // link idles with clock low and select high
  initial begin
    spi_clk = 1'b0;
    cs_n    = 1'b1;
    mosi    = 1'b0;
  end

  task automatic send(input logic [7:0] b[$], input int nbits);
    #400;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi = b[i / 8][7 - (i % 8)];
      #62.5 spi_clk = 1'b1;
      #62.5 spi_clk = 1'b0;
    end
    // clock idle before select rises, so the last bit lands first
    #150 cs_n = 1'b1;
    mosi = ~mosi; // released line shows no stale value
  endtask
endmodule

//--- tb/tb_top.sv
/*
 * Self-checking bench of the page program sequencer with a flash array
 * model. Assumes the host model above drives the link.
 */
`timescale 1ns/10ps
`include "flash_seq_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic        sys_clk;
  logic        rst_n;
  logic        page_528;
  logic        array_fail;
  logic [7:0]  array_rdata;
  wire         spi_clk;
  wire         cs_n;
  wire         mosi;
  logic        ready_flag;
  logic        program_erase_fail_flag;
  logic        array_erase;
  logic        array_we;
  logic [7:0]  array_wdata;
  logic [11:0] array_page;
  logic [9:0]  array_col;
  int          bad_count;
  int          total_checks;
  int          erase_cnt;
  logic [7:0]  wr_mask;
  logic [7:0]  mem [int];

  host_link_model host_link_model_inst (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi));

  page_program_sequencer page_program_sequencer_inst (
    .sys_clk                 (sys_clk),
    .rst_n                   (rst_n),
    .spi_clk                 (spi_clk),
    .cs_n                    (cs_n),
    .mosi                    (mosi),
    .page_528                (page_528),
    .array_rdata             (array_rdata),
    .array_fail              (array_fail),
    .ready_flag              (ready_flag),
    .program_erase_fail_flag (program_erase_fail_flag),
    .array_erase             (array_erase),
    .array_we                (array_we),
    .array_wdata             (array_wdata),
    .array_page              (array_page),
    .array_col               (array_col)
  );

  function automatic int key(input logic [11:0] p, input logic [9:0] c);
    return int'({p, c});
  endfunction

  // erased or never written cells read as all ones
  function automatic logic [7:0] rd(input logic [11:0] p, input logic [9:0] c);
    return mem.exists(key(p, c)) ? mem[key(p, c)] : 8'hFF;
  endfunction

  // array model: read answers one cycle after its address
  always @(posedge sys_clk) begin
    array_rdata <= rd(array_page, array_col);
    if (array_erase) begin
      erase_cnt++;
      for (int c = 0; c < 1024; c++) mem.delete(key(array_page, c[9:0]));
    end
    if (array_we) mem[key(array_page, array_col)] = array_wdata & wr_mask; // stuck bits
  end

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // opcode and address header, 2 or 3 dummy bits
  function automatic void frame(ref logic [7:0] q[$], input logic [7:0] op,
                                input logic [11:0] pg, input logic [9:0] off, input logic m);
    logic [23:0] a;
    a = m ? {2'b00, pg, off} : {3'b000, pg, off[8:0]};
    q = {op, a[23:16], a[15:8], a[7:0]};
  endfunction

  task automatic run(input logic [7:0] q[$], input int nbits, output int busy);
    int t;
    host_link_model_inst.send(q, nbits);
    busy = 0;
    t = 0;
    while (ready_flag === 1'b1 && t < 12) begin @(posedge sys_clk); t++; end
    while (ready_flag === 1'b0 && busy < 20000) begin @(posedge sys_clk); busy++; end
  endtask

  task automatic set_mode(input logic m);
    @(posedge sys_clk) page_528 <= m;
    repeat (8) @(posedge sys_clk);
  endtask

  // four bytes from the last two offsets wrap to offsets 0 and 1
  task automatic pe_wrap(input logic [7:0] op, input logic m, input logic [11:0] pg);
    logic [7:0] q[$];
    int len, busy, e0;
    len = m ? 528 : 512;
    set_mode(m);
    frame(q, op, pg, 10'(len - 2), m);
    for (int k = 0; k < 4; k++) q.push_back(8'hA0 + 8'(k));
    e0 = erase_cnt;
    run(q, 64, busy);
    `CHK("busy seen", 1'b1, busy > 50)
    `CHK("erase pulses", e0 + 1, erase_cnt)
    for (int k = 0; k < 4; k++)
      `CHK("page byte", 8'hA0 + 8'(k), rd(pg, 10'((len - 2 + k) % len)))
  endtask

  // only loaded bytes are written, time scales with count
  task automatic bp_two();
    logic [7:0] q[$];
    int busy, e0;
    set_mode(1'b0);
    mem[key(12'h005, 10'h006)] = 8'h5A;
    mem[key(12'h005, 10'h009)] = 8'hA5;
    frame(q, `OPC_BYTE_PROG, 12'h005, 10'h007, 1'b0);
    q.push_back(8'h11);
    q.push_back(8'h22);
    e0 = erase_cnt;
    run(q, 48, busy);
    `CHK("bp byte 7", 8'h11, rd(12'h005, 10'h007))
    `CHK("bp byte 8", 8'h22, rd(12'h005, 10'h008))
    `CHK("bp byte 6", 8'h5A, rd(12'h005, 10'h006))
    `CHK("bp byte 9", 8'hA5, rd(12'h005, 10'h009))
    `CHK("bp no erase", e0, erase_cnt)
    `CHK("bp time", 1'b1, busy >= 2 * 7 - 1 && busy <= 2 * 7 + 2)
  endtask

  // a frame ending mid byte does nothing, even after a whole data byte
  task automatic bp_abort(input logic [7:0] op);
    logic [7:0] q[$];
    int busy;
    frame(q, op, 12'h005, 10'h014, 1'b0);
    q.push_back(8'h33);
    q.push_back(8'h44);
    run(q, 43, busy);
    `CHK("abort busy", 0, busy)
    `CHK("abort byte", 8'hFF, rd(12'h005, 10'h014))
  endtask

  // modify keeps neighbours; empty modify rewrites and flags a fault
  task automatic rmw_pair(input logic m);
    logic [7:0] q[$];
    int busy;
    set_mode(m);
    mem[key(12'h009, 10'h014)] = 8'h11;
    mem[key(12'h009, 10'h015)] = 8'h22;
    frame(q, `OPC_RMW_B2, 12'h009, 10'h015, m);
    q.push_back(8'h77);
    run(q, 40, busy);
    `CHK("rmw kept", 8'h11, rd(12'h009, 10'h014))
    `CHK("rmw new", 8'h77, rd(12'h009, 10'h015))
    `CHK("rmw busy", 1'b1, busy > 528)
    @(posedge sys_clk) array_fail <= 1'b1;
    frame(q, `OPC_RMW_B1, 12'h009, 10'h000, m);
    run(q, 32, busy);
    array_fail <= 1'b0;
    `CHK("rewrite old", 8'h11, rd(12'h009, 10'h014))
    `CHK("rewrite new", 8'h77, rd(12'h009, 10'h015))
    `CHK("fail flag", 1'b1, program_erase_fail_flag)
  endtask

  // clean launch clears the flag; a byte that reads back wrong sets it
  task automatic bp_fail();
    logic [7:0] q[$];
    int busy;
    frame(q, `OPC_BYTE_PROG, 12'h00A, 10'h000, 1'b1);
    q.push_back(8'hC3);
    run(q, 40, busy);
    `CHK("clean flag", 1'b0, program_erase_fail_flag)
    `CHK("clean byte", 8'hC3, rd(12'h00A, 10'h000))
    wr_mask <= 8'h0F;
    run(q, 40, busy);
    wr_mask <= 8'hFF;
    `CHK("bad write flag", 1'b1, program_erase_fail_flag)
  endtask

  initial begin
    #1_500_000;
    bad_count++;
    complete_run();
  end

  initial begin
    rst_n      = 1'b0;
    page_528   = 1'b0;
    array_fail = 1'b0;
    bad_count  = 0;
    total_checks = 0;
    erase_cnt  = 0;
    wr_mask    = 8'hFF;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK("reset ready", 1'b1, ready_flag)
    `CHK("reset fail", 1'b0, program_erase_fail_flag)
    pe_wrap(`OPC_PROG_ERASE_B1, 1'b0, 12'h003);
    pe_wrap(`OPC_PROG_ERASE_B2, 1'b1, 12'h7FF);
    bp_two();
    bp_abort(`OPC_BYTE_PROG);
    bp_abort(`OPC_RMW_B1);
    rmw_pair(1'b0);
    rmw_pair(1'b1);
    bp_fail();
    complete_run();
  end
endmodule
